// file: shared/ptc_pkg.sv
`default_nettype none
package ptc_pkg;
    // register addresses on the plain port
    localparam logic [2:0] ADDR_CTRL   = 3'h0;
    localparam logic [2:0] ADDR_LOW    = 3'h1;
    localparam logic [2:0] ADDR_HIGH   = 3'h2;
    localparam logic [2:0] ADDR_STATUS = 3'h3;
    localparam logic [2:0] ADDR_MASK   = 3'h4;
    // control register fields
    localparam int CTRL_RUN   = 7;
    localparam int CTRL_WIDTH = 6;
    localparam int CTRL_SRC   = 5;
    localparam int CTRL_EDGE  = 4;
    localparam int CTRL_PSA   = 3;
    localparam int CTRL_PS_HI = 2;
    localparam logic [7:0] CTRL_RESET = 8'hFF;
    // status bit
    localparam int STAT_OVF = 0;
    // instruction clock divider: 4 system clocks per instruction cycle
    localparam logic [1:0] ICLK_DIV_LAST = 2'h3;
    // counting suppressed for two instruction cycles after a write
    localparam logic [1:0] WRITE_HOLD_CYCLES = 2'h2;
endpackage
`default_nettype wire

// file: hdl/ptc_edge_sync.sv
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser and selectable edge detector
module ptc_edge_sync (
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    input  wire logic pin_i,
    input  wire logic falling_i,
    output logic      edge_o
);
    logic meta_q;
    logic sync_q;
    logic last_q;
    wire  rise_w = sync_q & ~last_q;
    wire  fall_w = ~sync_q & last_q;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign edge_o = falling_i ? fall_w : rise_w;
endmodule
`default_nettype wire

// file: hdl/ptc_timer.sv
// Behaviour
// - ratio codes 010, 001, 000 give 1:8, 1:4, 1:2.
// - ratio codes 101, 100, 011 give 1:64, 1:32, 1:16; 110 and 111 give 1:128 and 1:256.
// - the source select bit picks the instruction clock when clear and the external pin when set.
// - timer mode without prescaler advances once per instruction clock.
// - any count write suppresses counting for the next two instruction cycles.
// - the edge select bit picks rising edges when clear and falling edges when set.
// - the external pin is synchronised before it can advance the counter.
// - in 16-bit width a low byte read copies the true high byte into the high buffer.
// - in 16-bit width the high buffer is moved into the true high byte when the low byte is written.
// - the prescaler is an 8-bit counter not readable or writable by software.
// - a clear assignment bit puts the prescaler in the count path.
// - while assigned, any count write clears the prescaler count.
// - clearing the prescaler on a count write leaves assignment and ratio unchanged.
// - overflow flag sets on FFh to 00h in 8-bit width or FFFFh to 0000h in 16-bit width.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module ptc_timer (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic       count_pin_i,
    output logic      [7:0] rdata_o,
    output logic            irq_o,
    output logic            overflow_flag_o
);
    logic [7:0]  ctrl_q;
    logic [7:0]  low_q;
    logic [7:0]  high_q;
    logic [7:0]  hbuf_q;
    logic [7:0]  presc_q;
    logic [1:0]  idiv_q;
    logic [1:0]  hold_q;
    logic        ovf_q;
    logic        mask_q;
    logic [7:0]  rdata_q;
    logic        irq_q;
    logic        pin_edge;

    // register decode
    wire wr_ctrl_w  = wr_i & (addr_i == ptc_pkg::ADDR_CTRL);
    wire wr_low_w   = wr_i & (addr_i == ptc_pkg::ADDR_LOW);
    wire wr_high_w  = wr_i & (addr_i == ptc_pkg::ADDR_HIGH);
    wire wr_mask_w  = wr_i & (addr_i == ptc_pkg::ADDR_MASK);
    wire rd_low_w   = rd_i & (addr_i == ptc_pkg::ADDR_LOW);
    wire rd_stat_w  = rd_i & (addr_i == ptc_pkg::ADDR_STATUS);

    // control fields
    wire       run_enable_bit       = ctrl_q[ptc_pkg::CTRL_RUN];
    wire       width_select_bit     = ctrl_q[ptc_pkg::CTRL_WIDTH];
    wire       count_source_select  = ctrl_q[ptc_pkg::CTRL_SRC];
    wire       source_edge_select   = ctrl_q[ptc_pkg::CTRL_EDGE];
    wire       prescaler_assign_bit = ctrl_q[ptc_pkg::CTRL_PSA];
    wire [2:0] prescale_ratio_field = ctrl_q[ptc_pkg::CTRL_PS_HI:0];

    ptc_edge_sync u_sync (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (count_pin_i),
        .falling_i (source_edge_select),
        .edge_o    (pin_edge)
    );

    // instruction clock enable, one pulse per four system clocks
    wire icyc_w = (idiv_q == ptc_pkg::ICLK_DIV_LAST);

    wire src_evt_w = count_source_select ? pin_edge : icyc_w;

    wire count_write_w = wr_low_w;
    wire held_w        = (hold_q != 2'h0);
    wire evt_w         = run_enable_bit & src_evt_w & ~held_w & ~count_write_w;

    // ratio 2^(code+1); tick when low code+1 bits of the next count roll to zero
    wire [7:0] presc_next_w = presc_q + 8'h01;
    wire [8:0] ratio_mask_w = (9'h002 << prescale_ratio_field) - 9'h001;
    wire       presc_tick_w = ((presc_next_w & ratio_mask_w[7:0]) == 8'h00);

    wire inc_w = evt_w & (prescaler_assign_bit | presc_tick_w);

    wire        wrap8_w  = (low_q == 8'hFF);
    wire        wrap16_w = wrap8_w & (high_q == 8'hFF);
    wire        ovf_evt_w = inc_w & (width_select_bit ? wrap8_w : wrap16_w);
    wire [15:0] cnt_w     = {high_q, low_q};
    wire [15:0] cnt_inc_w = cnt_w + 16'h0001;

    // irq follows next status and mask
    wire mask_d = wr_mask_w ? wdata_i[0] : mask_q;
    wire ovf_d  = ovf_evt_w | (ovf_q & ~rd_stat_w);
    wire irq_d  = ovf_d & mask_d;

    // read mux
    logic [7:0] rdata_d;
    always_comb begin
        rdata_d = 8'h00;
        case (addr_i)
            ptc_pkg::ADDR_CTRL:   rdata_d = ctrl_q;
            ptc_pkg::ADDR_LOW:    rdata_d = low_q;
            ptc_pkg::ADDR_HIGH:   rdata_d = hbuf_q;
            ptc_pkg::ADDR_STATUS: rdata_d = {7'h00, ovf_q};
            ptc_pkg::ADDR_MASK:   rdata_d = {7'h00, mask_q};
            default:              rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            idiv_q <= 2'h0;
        end else begin
            idiv_q <= idiv_q + 2'h1;
        end
    end

    // control register written only by its own address
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ctrl_q <= ptc_pkg::CTRL_RESET;
            mask_q <= 1'b0;
        end else begin
            if (wr_ctrl_w) begin
                ctrl_q <= wdata_i;
            end
            if (wr_mask_w) begin
                mask_q <= wdata_i[0];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            hold_q <= 2'h0;
        end else if (count_write_w) begin
            hold_q <= ptc_pkg::WRITE_HOLD_CYCLES;
        end else if (held_w && icyc_w) begin
            hold_q <= hold_q - 2'h1;
        end
    end

    // while assigned, prescaler cleared by count write, else advanced on events
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            presc_q <= 8'h00;
        end else if (count_write_w && !prescaler_assign_bit) begin
            presc_q <= 8'h00;
        end else if (evt_w && !prescaler_assign_bit) begin
            presc_q <= presc_tick_w ? 8'h00 : presc_next_w;
        end
    end

    // count register; buffer moved in on low write in 16-bit width
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            low_q  <= 8'h00;
            high_q <= 8'h00;
        end else if (wr_low_w) begin
            low_q <= wdata_i;
            if (!width_select_bit) begin
                high_q <= hbuf_q;
            end
        end else if (inc_w) begin
            low_q <= cnt_inc_w[7:0];
            if (!width_select_bit) begin
                high_q <= cnt_inc_w[15:8];
            end
        end
    end

    // in 16-bit width a low read snapshots the true high byte
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            hbuf_q <= 8'h00;
        end else if (wr_high_w) begin
            hbuf_q <= wdata_i;
        end else if (rd_low_w && !width_select_bit) begin
            hbuf_q <= high_q;
        end
    end

    // sticky flag, set wins over read clear
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ovf_q   <= 1'b0;
            irq_q   <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            ovf_q   <= ovf_d;
            irq_q   <= irq_d;
            rdata_q <= rd_i ? rdata_d : 8'h00;
        end
    end

    assign rdata_o         = rdata_q;
    assign irq_o           = irq_q;
    assign overflow_flag_o = ovf_q;

    // reference count of events since the last tick
    logic [8:0] evt_seen_q;
    logic       ratio_clean_q;
    wire  [8:0] ratio_w = 9'h002 << prescale_ratio_field;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            evt_seen_q    <= 9'h000;
            ratio_clean_q <= 1'b0;
        end else if (count_write_w && !prescaler_assign_bit) begin
            evt_seen_q    <= 9'h000;
            ratio_clean_q <= 1'b1;
        end else begin
            if (wr_ctrl_w) begin
                ratio_clean_q <= 1'b0;
            end
            if (evt_w && !prescaler_assign_bit) begin
                evt_seen_q <= inc_w ? 9'h000 : evt_seen_q + 9'h001;
            end
        end
    end

    // assertions
    a_wrap_sets_flag: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ovf_evt_w |=> ovf_q)
        else $error("overflow did not set flag");

    a_wrap_zero_low: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ovf_evt_w && !wr_low_w |=> low_q == 8'h00)
        else $error("low byte not zero after wrap");

    a_write_hold_blocks: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        wr_low_w |=> !inc_w [*4])
        else $error("count advanced during write hold");

    a_write_clears_presc: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        wr_low_w && !prescaler_assign_bit |=> presc_q == 8'h00)
        else $error("prescaler not cleared by write");

    a_write_keeps_ctrl: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        wr_low_w |=> $stable(ctrl_q))
        else $error("count write changed control");

    a_low_write_high: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        wr_low_w && !width_select_bit |=> high_q == $past(hbuf_q))
        else $error("high byte not loaded from buffer");

    a_low_read_snap: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        rd_low_w && !width_select_bit |=> hbuf_q == $past(high_q))
        else $error("buffer missed high snapshot");

    a_stopped_holds: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !run_enable_bit && !wr_low_w |=> low_q == $past(low_q))
        else $error("count moved while stopped");

    a_bypass_every: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        evt_w && prescaler_assign_bit |-> inc_w)
        else $error("bypass missed an event");

    a_source_timer: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        inc_w && !count_source_select |-> icyc_w)
        else $error("timer advanced off instruction clock");

    a_source_pin: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        inc_w && count_source_select |-> pin_edge)
        else $error("counter advanced without pin edge");

    a_ratio_two: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        evt_w && !prescaler_assign_bit && prescale_ratio_field == 3'h0 && presc_q == 8'h00 |-> !inc_w)
        else $error("1:2 ratio ticked early");

    a_ratio_max: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        evt_w && !prescaler_assign_bit && prescale_ratio_field == 3'h7 |-> inc_w == (presc_q == 8'hFF))
        else $error("1:256 ratio wrong");

    a_presc_range: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        inc_w && !prescaler_assign_bit |=> presc_q == 8'h00)
        else $error("prescaler not restarted on tick");

    a_sync_delay: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        pin_edge |-> $past(count_pin_i, 2) != $past(count_pin_i, 3))
        else $error("edge not from synchronised pin");

    a_edge_fall: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        pin_edge && source_edge_select |-> !$past(count_pin_i, 2))
        else $error("falling edge mode saw rise");

    a_presc_hidden: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        rd_i && addr_i > ptc_pkg::ADDR_MASK |=> rdata_o == 8'h00)
        else $error("prescaler readable");

    sequence s_count_write;
        wr_low_w;
    endsequence

    sequence s_hold_armed;
        hold_q == ptc_pkg::WRITE_HOLD_CYCLES && !inc_w;
    endsequence

    a_hold_armed: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_count_write |=> s_hold_armed)
        else $error("write hold not armed");

    a_hold_releases: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        held_w && icyc_w && !count_write_w |=> hold_q == $past(hold_q) - 2'h1)
        else $error("write hold did not count down");

    // buffer write, quiet cycle, low write
    sequence s_pair_write;
        wr_high_w ##1 !wr_high_w && !rd_low_w ##1 wr_low_w && !width_select_bit;
    endsequence

    a_pair_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_pair_write |=> {high_q, low_q} == {$past(wdata_i, 3), $past(wdata_i)})
        else $error("16-bit write not atomic");

    a_high_read_buf: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        rd_i && addr_i == ptc_pkg::ADDR_HIGH |=> rdata_o == $past(hbuf_q))
        else $error("high address did not return buffer");

    a_narrow_high_frozen: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        width_select_bit |=> $stable(high_q))
        else $error("high byte moved in 8-bit width");

    a_count_step8: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        inc_w && width_select_bit |=> low_q == $past(low_q) + 8'h01)
        else $error("8-bit count did not step by one");

    a_count_step16: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        inc_w && !width_select_bit |=> {high_q, low_q} == $past(cnt_w) + 16'h0001)
        else $error("16-bit count did not step by one");

    // instruction clock enable every fourth clock
    sequence s_icyc_quiet;
        !icyc_w [*3];
    endsequence

    a_icyc_period: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        icyc_w |=> s_icyc_quiet ##1 icyc_w)
        else $error("instruction clock period wrong");

    a_timer_every: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        run_enable_bit && !count_source_select && prescaler_assign_bit && icyc_w && !held_w && !count_write_w
        |-> inc_w)
        else $error("timer missed an instruction cycle");

    a_ratio_count: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        evt_w && !prescaler_assign_bit && ratio_clean_q |-> inc_w == (evt_seen_q + 9'h001 == ratio_w))
        else $error("prescaler ratio miscounted");

    a_irq_level: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        irq_q == (ovf_q && mask_q))
        else $error("irq not equal to unmasked status");
endmodule
`default_nettype wire

// file: tb/ptc_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// external count source: toggles the pin a given number of times
module ptc_pin_model (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       start_i,
    input  wire logic [7:0] toggles_i,
    input  wire logic [3:0] half_i,
    output logic            pin_o,
    output logic            busy_o
);
    logic [7:0] left_q;
    logic [3:0] cnt_q;
    assign busy_o = (left_q != 8'h00);
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pin_o  <= 1'b0;
            left_q <= 8'h00;
            cnt_q  <= 4'h0;
        end else if (start_i && !busy_o) begin
            left_q <= toggles_i;
            cnt_q  <= half_i;
        end else if (busy_o && cnt_q == 4'h0) begin
            pin_o  <= ~pin_o;
            left_q <= left_q - 8'h01;
            cnt_q  <= half_i;
        end else if (busy_o) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule
`default_nettype wire

// file: tb/prescaled_timer_counter_tb.sv
`timescale 1ns/1ns
`default_nettype none
module prescaled_timer_counter_tb;
    logic       mclk_i = 1'b0;
    logic       sys_rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       start = 1'b0;
    logic [7:0] tog = 8'h00;
    logic [3:0] half = 4'h2;
    logic [7:0] rdata;
    logic       irq;
    logic       ovf;
    logic       pin;
    logic       busy;
    logic [31:0] seed = 32'h42B0128D;
    int         err_count = 0;
    int         samples_checked = 0;
    ptc_timer dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .count_pin_i(pin), .rdata_o(rdata), .irq_o(irq), .overflow_flag_o(ovf));
    ptc_pin_model pm (.mclk_i(mclk_i), .sys_rst_i(sys_rst), .start_i(start), .toggles_i(tog), .half_i(half),
        .pin_o(pin), .busy_o(busy));
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // edges of the chosen polarity in n toggles from a start level
    function automatic logic [7:0] edges_f(input logic lvl, input logic [7:0] n, input logic fall);
        logic [7:0] rise;
        rise = lvl ? (n >> 1) : ((n + 8'h01) >> 1);
        return fall ? (n - rise) : rise;
    endfunction
    task automatic wrr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask
    task automatic rdr(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        @(posedge mclk_i);
        d = rdata;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic near(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp && got !== exp + 8'h01 && got !== exp - 8'h01) begin
            err_count++;
            $display("[ERR] %0t count %h not near %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (err_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge mclk_i);
        err_count++;
        test_done();
    end
    initial begin
        logic [7:0] d;
        logic [31:0] v;
        logic lvl;
        int r;
        lvl = 1'b0;
        repeat (8) @(posedge mclk_i);
        sys_rst <= 1'b0;
        rdr(ptc_pkg::ADDR_CTRL, d);
        chk(d, ptc_pkg::CTRL_RESET);
        wrr(3'h5, 8'h5A);
        rdr(3'h5, d);
        chk(d, 8'h00);
        rdr(3'h7, d);
        chk(d, 8'h00);
        wrr(ptc_pkg::ADDR_CTRL, 8'hC8);
        wrr(ptc_pkg::ADDR_LOW, 8'h00);
        repeat (200) @(posedge mclk_i);
        rdr(ptc_pkg::ADDR_LOW, d);
        near(d, 8'h30);
        wrr(ptc_pkg::ADDR_CTRL, 8'h48);
        wrr(ptc_pkg::ADDR_LOW, 8'h77);
        repeat (100) @(posedge mclk_i);
        rdr(ptc_pkg::ADDR_LOW, d);
        chk(d, 8'h77);
        for (int c = 0; c < 8; c++) begin
            r = 2 << c;
            wrr(ptc_pkg::ADDR_CTRL, 8'hC0 | 8'(c));
            wrr(ptc_pkg::ADDR_LOW, 8'h00);
            repeat (16 * r + 12) @(posedge mclk_i);
            rdr(ptc_pkg::ADDR_LOW, d);
            near(d, 8'(((16 * r + 14) / 4 - 2) / r));
            rdr(ptc_pkg::ADDR_CTRL, d);
            chk(d, 8'hC0 | 8'(c));
        end
        for (int k = 0; k < 4; k++) begin
            v = xs();
            wrr(ptc_pkg::ADDR_CTRL, 8'hE8 | {3'h0, v[7], 4'h0});
            wrr(ptc_pkg::ADDR_LOW, 8'h00);
            repeat (12) @(posedge mclk_i);
            tog   <= {4'h0, v[3:0]} + 8'h01;
            half  <= {1'b0, v[6:4]} + 4'h2;
            start <= 1'b1;
            @(posedge mclk_i);
            start <= 1'b0;
            @(posedge mclk_i);
            for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge mclk_i);
            chk({7'h00, busy}, 8'h00);
            repeat (8) @(posedge mclk_i);
            rdr(ptc_pkg::ADDR_LOW, d);
            chk(d, edges_f(lvl, {4'h0, v[3:0]} + 8'h01, v[7]));
            lvl = lvl ^ ~v[0];
        end
        wrr(ptc_pkg::ADDR_CTRL, 8'h08);
        repeat (4) begin
            v = xs();
            wrr(ptc_pkg::ADDR_HIGH, v[15:8]);
            wrr(ptc_pkg::ADDR_LOW, v[7:0]);
            rdr(ptc_pkg::ADDR_LOW, d);
            chk(d, v[7:0]);
            rdr(ptc_pkg::ADDR_HIGH, d);
            chk(d, v[15:8]);
        end
        wrr(ptc_pkg::ADDR_CTRL, 8'h88);
        wrr(ptc_pkg::ADDR_HIGH, 8'h12);
        wrr(ptc_pkg::ADDR_LOW, 8'hF0);
        repeat (100) @(posedge mclk_i);
        rdr(ptc_pkg::ADDR_LOW, d);
        near(d, 8'h07);
        rdr(ptc_pkg::ADDR_HIGH, d);
        chk(d, 8'h13);
        wrr(ptc_pkg::ADDR_MASK, 8'h01);
        wrr(ptc_pkg::ADDR_CTRL, 8'hC8);
        wrr(ptc_pkg::ADDR_LOW, 8'hFE);
        repeat (40) @(posedge mclk_i);
        chk({6'h0, irq, ovf}, 8'h03);
        rdr(ptc_pkg::ADDR_STATUS, d);
        chk(d, 8'h01);
        repeat (2) @(posedge mclk_i);
        chk({6'h0, irq, ovf}, 8'h00);
        wrr(ptc_pkg::ADDR_MASK, 8'h00);
        wrr(ptc_pkg::ADDR_LOW, 8'hFE);
        repeat (40) @(posedge mclk_i);
        chk({6'h0, irq, ovf}, 8'h01);
        rdr(ptc_pkg::ADDR_STATUS, d);
        chk(d, 8'h01);
        wrr(ptc_pkg::ADDR_CTRL, 8'h88);
        wrr(ptc_pkg::ADDR_HIGH, 8'h00);
        wrr(ptc_pkg::ADDR_LOW, 8'hFE);
        repeat (40) @(posedge mclk_i);
        chk({6'h0, irq, ovf}, 8'h00);
        wrr(ptc_pkg::ADDR_HIGH, 8'hFF);
        wrr(ptc_pkg::ADDR_LOW, 8'hFE);
        repeat (40) @(posedge mclk_i);
        chk({6'h0, irq, ovf}, 8'h01);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk_i);
        sys_rst <= 1'b0;
        chk({6'h0, irq, ovf}, 8'h00);
        rdr(ptc_pkg::ADDR_CTRL, d);
        chk(d, ptc_pkg::CTRL_RESET);
        test_done();
    end
endmodule
`default_nettype wire
